//--- hw/sac_pkg.sv
// Shared constants and types for the sampling converter's readout link.
// Assumes a single 100 MHz system clock on both ends.
package sac_pkg;
	localparam int RES_W = 14;
	localparam int CLK_PERIOD_NS = 10;
	// Least conversion time, rounded up to whole cycles
	localparam int CONVERT_START_INPUT_NS = 225;
	localparam int CONVERT_START_INPUT_CYC = (CONVERT_START_INPUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Least acquisition time, rounded up
	localparam int ACQ_NS = 175;
	localparam int ACQ_CYC = (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Least width of a power-mode pulse on the convert input
	localparam int PULSE_NS = 10;
	localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Reference recovery after sleep, in microseconds
	localparam int WAKE_SLEEP_US = 1100;
	localparam int WAKE_SLEEP_CYC = WAKE_SLEEP_US * 1000 / CLK_PERIOD_NS;
	// One approximation step per tick; the whole word fits the conversion time
	localparam int SAR_STEP_CYC = (CONVERT_START_INPUT_CYC / RES_W) < 1 ? 1 : (CONVERT_START_INPUT_CYC / RES_W);
	localparam logic [2:0] NAP_PULSES = 3'h2;
	localparam logic [2:0] SLEEP_PULSES = 3'h4;
	localparam int SCK_HALF_CYC = 4;
	typedef enum logic [1:0] {
		SAC_OP_CONVERT,
		SAC_OP_NAP,
		SAC_OP_SLEEP,
		SAC_OP_WAKE
	} sac_op_t;
endpackage

//--- hw/sac_link_if.sv
// Three-wire link between the converter end and its serial master.
// The data line is split into level and output enable; the host reads the level.
`timescale 1ns/1ps
`default_nettype none
interface sac_link_if;
	logic convert_start_input;
	logic sck;
	logic sdo;
	logic sdo_oe_n;
	modport dev (input convert_start_input, input sck, output sdo, output sdo_oe_n);
	modport host (output convert_start_input, output sck, input sdo, input sdo_oe_n);
endinterface
`default_nettype wire

//--- hw/sac_dev.sv
// Converter end: conversion timing, approximation, serial shift-out, power modes.
// Assumes convert and shift clock come from the host asynchronously to CLK.
`timescale 1ns/1ps
`default_nettype none
module sac_dev
	import sac_pkg::*;
#(
	parameter int AIN_W = 16
) (
	input wire logic CLK,
	input wire logic RSTN,
	sac_link_if.dev LINK,
	input wire logic signed [AIN_W-1:0] AIN,
	output logic BUSY,
	output logic SAMPLING,
	output logic NAP_MODE,
	output logic SLEEP_MODE,
	output logic BIAS_ON,
	output logic [sac_pkg::RES_W-1:0] RESULT
);
	import sac_pkg::*;

	localparam logic [3:0] LAST_STEP = 4'(RES_W - 1);
	localparam logic [7:0] TICK_RELOAD = 8'(SAR_STEP_CYC - 1);

	typedef struct packed {
		logic [1:0] convert_start_input_s;
		logic convert_start_input_d;
		logic [1:0] sck_s;
		logic sck_d;
		logic signed [AIN_W-1:0] ain_s0;
		logic signed [AIN_W-1:0] ain_s1;
		logic signed [AIN_W-1:0] track;
		logic busy;
		logic [3:0] step;
		logic [7:0] tick;
		logic signed [AIN_W-1:0] held;
		logic [RES_W-1:0] trial;
		logic [RES_W-1:0] result;
		logic [RES_W-1:0] shreg;
		logic sdo;
		logic oe_n;
		logic sampling;
		logic [2:0] pulses;
		logic nap;
		logic sleep;
		logic bias_on;
	} sac_dev_st_t;

	sac_dev_st_t q;
	sac_dev_st_t n;
	logic convert_start_input_rise;
	logic convert_start_input_fall;
	logic sck_edge;
	logic sck_fall;
	logic keep;
	logic [RES_W-1:0] bitm;
	logic [RES_W-1:0] trial;
	logic [RES_W-1:0] res_next;
	logic signed [AIN_W-1:0] trial_ext;
	logic convert_start_input_done;

	// Edge of a synchronised level against its delayed copy
	function automatic logic edge_up(input logic now_v, input logic was_v);
		edge_up = now_v & ~was_v;
	endfunction

	function automatic logic edge_down(input logic now_v, input logic was_v);
		edge_down = ~now_v & was_v;
	endfunction

	// One-hot trial bit, MSB first
	function automatic logic [RES_W-1:0] sar_mask(input logic [3:0] idx);
		sar_mask = '0;
		sar_mask[LAST_STEP - idx] = 1'b1;
	endfunction

	always_comb begin
		n = q;
		// Pin synchronisers
		n.convert_start_input_s = {q.convert_start_input_s[0], LINK.convert_start_input};
		n.convert_start_input_d = q.convert_start_input_s[1];
		n.sck_s = {q.sck_s[0], LINK.sck};
		n.sck_d = q.sck_s[1];
		n.ain_s0 = AIN;
		n.ain_s1 = q.ain_s0;
		// Track only while sampling, and only a word seen twice alike
		if (q.sampling && q.ain_s0 == q.ain_s1) begin
			n.track = q.ain_s1;
		end

		convert_start_input_rise = edge_up(q.convert_start_input_s[1], q.convert_start_input_d);
		convert_start_input_fall = edge_down(q.convert_start_input_s[1], q.convert_start_input_d);
		sck_edge = edge_up(q.sck_s[1], q.sck_d) | edge_down(q.sck_s[1], q.sck_d);
		sck_fall = edge_down(q.sck_s[1], q.sck_d);
		convert_start_input_done = 1'b0;

		// Successive approximation, one bit per tick
		bitm = sar_mask(q.step);
		trial = q.trial | bitm;
		// Compare against zero-extended trial: negative input keeps no bit,
		// over-range input keeps every bit
		trial_ext = $signed({{(AIN_W - RES_W){1'b0}}, trial});
		keep = q.held >= trial_ext;
		res_next = keep ? trial : q.trial;
		if (q.busy) begin
			if (q.tick == '0) begin
				n.tick = TICK_RELOAD;
				n.trial = res_next;
				if (q.step == LAST_STEP) begin
					n.busy = 1'b0;
					n.result = res_next;
					convert_start_input_done = 1'b1;
				end else begin
					n.step = q.step + 4'h1;
				end
			end else begin
				n.tick = q.tick - 8'h01;
			end
		end

		if (convert_start_input_rise) begin
			// Internal tick, not the shift clock, paces the steps
			n.busy = 1'b1;
			n.step = '0;
			n.tick = TICK_RELOAD;
			n.trial = '0;
			n.held = q.track;
			n.sampling = 1'b0;
			if (q.pulses != SLEEP_PULSES) begin
				n.pulses = q.pulses + 3'h1;
			end
			if (n.pulses == NAP_PULSES) begin
				n.nap = 1'b1;
			end
			if (n.pulses == SLEEP_PULSES) begin
				n.sleep = 1'b1;
				n.nap = 1'b0;
			end
		end
		if (sck_edge) begin
			n.pulses = '0;
			n.nap = 1'b0;
			n.sleep = 1'b0;
		end
		// Finished conversion naps even against a shift clock edge
		if (convert_start_input_done && !n.sleep) begin
			n.nap = 1'b1;
		end

		// Serial output
		if (q.convert_start_input_s[1]) begin
			n.oe_n = 1'b1;
		end
		if (convert_start_input_fall) begin
			n.oe_n = 1'b0;
			n.shreg = q.result;
			n.sdo = q.result[RES_W-1];
			n.sampling = 1'b1;
		end else if (sck_fall && !q.oe_n) begin
			n.shreg = {q.shreg[RES_W-2:0], 1'b0};
			n.sdo = q.shreg[RES_W-2];
		end

		// Bias follows sleep alone; nap keeps it on
		n.bias_on = ~n.sleep;
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			q <= '{
				default: '0,
				oe_n: 1'b1,
				sampling: 1'b1,
				bias_on: 1'b1
			};
		end else begin
			q <= n;
		end
	end

	assign LINK.sdo = q.sdo;
	assign LINK.sdo_oe_n = q.oe_n;
	assign BUSY = q.busy;
	assign SAMPLING = q.sampling;
	assign NAP_MODE = q.nap;
	assign SLEEP_MODE = q.sleep;
	assign BIAS_ON = q.bias_on;
	assign RESULT = q.result;
endmodule
`default_nettype wire

//--- hw/sac_host.sv
// Serial master end: convert pulses, shift clock, power commands, word buffer.
// Assumes the data line arrives asynchronously and is synchronised here.
`timescale 1ns/1ps
`default_nettype none
module sac_host
	import sac_pkg::*;
#(
	parameter int WAKE_CYC = sac_pkg::WAKE_SLEEP_CYC,
	parameter int DEPTH = 2,
	parameter int HALF_CYC = sac_pkg::SCK_HALF_CYC
) (
	input wire logic CLK,
	input wire logic RSTN,
	sac_link_if.host LINK,
	input wire logic CMD_VALID,
	input wire sac_pkg::sac_op_t CMD_OP,
	output logic CMD_READY,
	output logic BUSY,
	output logic ASLEEP,
	output logic [sac_pkg::RES_W-1:0] DATA,
	output logic DATA_VALID,
	input wire logic DATA_READY
);
	import sac_pkg::*;

	localparam int CNT_W = $clog2(WAKE_CYC + CONVERT_START_INPUT_CYC + 2);
	localparam logic [3:0] LAST_BIT = 4'(RES_W - 1);

	typedef enum logic [3:0] {
		H_IDLE, H_CONVERT_START_INPUT, H_RD_LO, H_RD_HI, H_ACQ, H_P_HI, H_P_LO, H_W_HI, H_W_LO, H_W_WAIT
	} sac_hst_t;

	typedef struct packed {
		sac_hst_t st;
		logic [CNT_W-1:0] cnt;
		logic [3:0] nbit;
		logic [2:0] npulse;
		logic [RES_W-1:0] sh_in;
		logic [1:0] sdo_s;
		logic convert_start_input;
		logic sck;
		logic asleep;
		logic sleep_req;
		logic cmd_ready;
		logic busy;
		logic [DEPTH-1:0][RES_W-1:0] mem;
		logic [DEPTH-1:0] vld;
	} sac_host_st_t;

	sac_host_st_t q;
	sac_host_st_t n;
	logic push;
	logic [RES_W-1:0] push_word;
	logic pop;
	logic placed;

	function automatic logic [CNT_W-1:0] cnt_of(input int cycles);
		cnt_of = CNT_W'(cycles - 1);
	endfunction

	always_comb begin
		n = q;
		push = 1'b0;
		push_word = {q.sh_in[RES_W-2:0], q.sdo_s[1]};
		n.sdo_s = {q.sdo_s[0], LINK.sdo};
		if (q.cnt != '0) begin
			n.cnt = q.cnt - CNT_W'(1);
		end
		case (q.st)
			H_IDLE: begin
				if (CMD_VALID && q.cmd_ready) begin
					case (CMD_OP)
						SAC_OP_CONVERT: begin
							n.convert_start_input = 1'b1;
							n.cnt = cnt_of(CONVERT_START_INPUT_CYC);
							n.st = H_CONVERT_START_INPUT;
						end
						SAC_OP_NAP, SAC_OP_SLEEP: begin
							// Shift clock stays still through the pulse train
							n.sleep_req = CMD_OP == SAC_OP_SLEEP;
							n.npulse = CMD_OP == SAC_OP_SLEEP ? SLEEP_PULSES : NAP_PULSES;
							n.convert_start_input = 1'b1;
							n.cnt = cnt_of(PULSE_CYC);
							n.st = H_P_HI;
						end
						default: begin
							n.sck = 1'b1;
							n.cnt = cnt_of(HALF_CYC);
							n.st = H_W_HI;
						end
					endcase
				end
			end
			H_CONVERT_START_INPUT: begin
				if (q.cnt == '0) begin
					n.convert_start_input = 1'b0;
					n.nbit = '0;
					n.cnt = cnt_of(HALF_CYC);
					n.st = H_RD_LO;
				end
			end
			H_RD_LO: begin
				if (q.cnt == '0) begin
					n.sck = 1'b1;
					n.cnt = cnt_of(HALF_CYC);
					n.st = H_RD_HI;
				end
			end
			H_RD_HI: begin
				if (q.cnt == '0) begin
					n.sh_in = push_word;
					n.sck = 1'b0;
					n.cnt = cnt_of(HALF_CYC);
					if (q.nbit == LAST_BIT) begin
						push = 1'b1;
						n.cnt = cnt_of(ACQ_CYC);
						n.st = H_ACQ;
					end else begin
						n.nbit = q.nbit + 4'h1;
						n.st = H_RD_LO;
					end
				end
			end
			H_ACQ: begin
				if (q.cnt == '0) begin
					n.st = H_IDLE;
				end
			end
			H_P_HI: begin
				if (q.cnt == '0) begin
					n.convert_start_input = 1'b0;
					n.npulse = q.npulse - 3'h1;
					n.cnt = cnt_of(PULSE_CYC);
					n.st = H_P_LO;
				end
			end
			H_P_LO: begin
				if (q.cnt == '0) begin
					if (q.npulse == '0) begin
						n.asleep = q.sleep_req;
						n.st = H_IDLE;
					end else begin
						n.convert_start_input = 1'b1;
						n.cnt = cnt_of(PULSE_CYC);
						n.st = H_P_HI;
					end
				end
			end
			H_W_HI: begin
				if (q.cnt == '0) begin
					n.sck = 1'b0;
					n.cnt = cnt_of(HALF_CYC);
					n.st = H_W_LO;
				end
			end
			H_W_LO: begin
				if (q.cnt == '0) begin
					n.asleep = 1'b0;
					if (q.asleep) begin
						n.cnt = cnt_of(WAKE_CYC);
						n.st = H_W_WAIT;
					end else begin
						n.st = H_IDLE;
					end
				end
			end
			H_W_WAIT: begin
				if (q.cnt == '0) begin
					n.st = H_IDLE;
				end
			end
			default: begin
				n.st = H_IDLE;
			end
		endcase
		// Shift-down buffer: head entry feeds the outputs directly
		pop = q.vld[0] & DATA_READY;
		if (pop) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				n.mem[i] = q.mem[i+1];
				n.vld[i] = q.vld[i+1];
			end
			n.vld[DEPTH-1] = 1'b0;
		end
		placed = 1'b0;
		for (int i = 0; i < DEPTH; i++) begin
			if (push && !placed && !n.vld[i]) begin
				n.mem[i] = push_word;
				n.vld[i] = 1'b1;
				placed = 1'b1;
			end
		end
		// A full buffer refuses new commands, so no read word is ever dropped
		n.cmd_ready = (n.st == H_IDLE) && !n.vld[DEPTH-1];
		n.busy = n.st != H_IDLE;
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			q <= '{default: '0, st: H_IDLE};
		end else begin
			q <= n;
		end
	end

	assign LINK.convert_start_input = q.convert_start_input;
	assign LINK.sck = q.sck;
	assign CMD_READY = q.cmd_ready;
	assign BUSY = q.busy;
	assign ASLEEP = q.asleep;
	assign DATA = q.mem[0];
	assign DATA_VALID = q.vld[0];
endmodule
`default_nettype wire

//--- tb/sac_link_props.sv
// Link checker: data line tristate, shift timing, zero fill, conversion pacing.
// Assumes one shared CLK and convert_start_input/sck driven from host flops.
`timescale 1ns/1ps
`default_nettype none
module sac_link_props
	import sac_pkg::*;
(
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic convert_start_input,
	input wire logic sck,
	input wire logic sdo,
	input wire logic sdo_oe_n
);
	import sac_pkg::*;
	logic [7:0] hi_q;
	logic [7:0] lo_q;
	logic [3:0] since_q;
	logic [4:0] falls_q;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	// High length, cycles since a shift edge, falls since convert
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			hi_q <= 8'h00;
			lo_q <= 8'hff;
			since_q <= 4'h0;
			falls_q <= 5'h00;
		end else begin
			hi_q <= convert_start_input ? hi_q + 8'h01 : 8'h00;
			lo_q <= convert_start_input ? 8'h00 : lo_q + {7'h00, lo_q != 8'hff};
			since_q <= ($fell(sck) || $fell(convert_start_input)) ? 4'h0 : since_q + {3'h0, since_q != 4'hf};
			falls_q <= convert_start_input ? 5'h00 : falls_q + {4'h0, $fell(sck) && falls_q != 5'h1f};
		end
	end
	property p_off_hi; convert_start_input[*5] |-> sdo_oe_n; endproperty
	a_off_hi: assert property (p_off_hi) else $error("data line driven in convert high");
	property p_off_rise; $rose(convert_start_input) |-> ##[2:5] sdo_oe_n; endproperty
	a_off_rise: assert property (p_off_rise) else $error("data line not released");
	property p_on_fall; $fell(convert_start_input) |-> ##[2:5] !sdo_oe_n; endproperty
	a_on_fall: assert property (p_on_fall) else $error("data line not enabled");
	property p_on_hold; !convert_start_input[*6] ##0 !sdo_oe_n |=> !sdo_oe_n; endproperty
	a_on_hold: assert property (p_on_hold) else $error("data line dropped while low");
	property p_shift; !sdo_oe_n && $past(!sdo_oe_n) && $changed(sdo) |-> since_q <= 4'h6; endproperty
	a_shift: assert property (p_shift) else $error("data changed without shift edge");
	property p_zero; falls_q >= 5'h0e && since_q > 4'h5 && !sdo_oe_n |-> !sdo; endproperty
	a_zero: assert property (p_zero) else $error("nonzero after last bit");
	property p_convert_start_input_len; $fell(convert_start_input) |-> hi_q >= CONVERT_START_INPUT_CYC || hi_q == PULSE_CYC; endproperty
	a_convert_start_input_len: assert property (p_convert_start_input_len) else $error("convert high too short");
	property p_sck_still; convert_start_input && $past(convert_start_input) |-> $stable(sck); endproperty
	a_sck_still: assert property (p_sck_still) else $error("shift clock moved in conversion");
	property p_acq; $rose(convert_start_input) && lo_q != PULSE_CYC |-> lo_q >= ACQ_CYC; endproperty
	a_acq: assert property (p_acq) else $error("acquisition time too short");
	c_convert_start_input: cover property ($fell(convert_start_input) && hi_q >= CONVERT_START_INPUT_CYC);
	c_pulse: cover property ($fell(convert_start_input) && hi_q == 8'h01);
	c_tail: cover property (falls_q == 5'h0e);
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Both link ends joined; converter fed codes, host reads words and sends power commands.
// Assumes a shortened sleep wake wait.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import sac_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic cmd_valid = 1'b0;
	sac_op_t cmd_op = SAC_OP_CONVERT;
	logic data_ready = 1'b0;
	logic signed [15:0] ain = 16'sh0000;
	logic cmd_ready, h_busy, asleep, data_valid, d_busy, sampling, nap, slp, bias;
	logic [RES_W-1:0] data, result;
	int failures = 0;
	int checked = 0;
	int cyc = 0;
	int busy_cyc = 0;
	localparam int WAKE_T = 50;
	int q[$];
	int edge_v[8] = '{-32768, -1, 0, 1, 8192, 16383, 16384, 32767};
	sac_link_if link();
	sac_dev sac_dev_i(.CLK(clk), .RSTN(rstn), .LINK(link), .AIN(ain), .BUSY(d_busy), .SAMPLING(sampling),
		.NAP_MODE(nap), .SLEEP_MODE(slp), .BIAS_ON(bias), .RESULT(result));
	sac_host #(.WAKE_CYC(WAKE_T)) sac_host_i(.CLK(clk), .RSTN(rstn), .LINK(link), .CMD_VALID(cmd_valid),
		.CMD_OP(cmd_op), .CMD_READY(cmd_ready), .BUSY(h_busy), .ASLEEP(asleep), .DATA(data),
		.DATA_VALID(data_valid), .DATA_READY(data_ready));
	sac_link_props props_i(.CLK(clk), .RSTN(rstn), .convert_start_input(link.convert_start_input), .sck(link.sck), .sdo(link.sdo),
		.sdo_oe_n(link.sdo_oe_n));
	always #5 clk = ~clk;
	task automatic step(int n = 1);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic test_done();
		$display("Checks %0d, failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic cmd(sac_op_t op);
		while (cmd_ready !== 1'b1) step();
		cmd_valid = 1'b1;
		cmd_op = op;
		step();
		cmd_valid = 1'b0;
		busy_cyc = 0;
		while (h_busy !== 1'b0) begin
			step();
			busy_cyc++;
		end
		step(20);
	endtask
	// Model: clamp to the code range, queue in issue order
	task automatic start(int v);
		ain = 16'(v);
		q.push_back(v < 0 ? 0 : v > 16383 ? 16383 : v);
		cmd_op = SAC_OP_CONVERT;
		while (cmd_ready !== 1'b1) step();
		cmd_valid = 1'b1;
		step();
		cmd_valid = 1'b0;
		while (d_busy !== 1'b1) step();
		while (d_busy !== 1'b0) step();
		chk("result", q[$], result);
		chk("hold_in_convert_start_input", 0, sampling);
		chk("nap_after_convert_start_input", 1, nap);
		chk("sdo_off", 1, link.sdo_oe_n);
		while (h_busy !== 1'b0) step();
	endtask
	task automatic rd();
		while (data_valid !== 1'b1) step();
		chk("word", q.pop_front(), data);
		chk("sampling", 1, sampling);
		data_ready = 1'b1;
		step();
		data_ready = 1'b0;
		step();
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			failures++;
			test_done();
		end
	end
	initial begin
		void'($urandom(12));
		step(5);
		rstn = 1'b1;
		step(2);
		foreach (edge_v[i]) begin
			start(edge_v[i]);
			rd();
		end
		repeat (6) begin
			start(int'($urandom_range(16583, 0)) - 100);
			rd();
		end
		start(100);
		start(200);
		step(20);
		chk("refuse_full", 0, cmd_ready);
		rd();
		rd();
		chk("empty", 0, data_valid);
		cmd(SAC_OP_NAP);
		chk("nap", 1, nap);
		chk("nap_not_sleep", 0, slp);
		chk("nap_bias", 1, bias);
		cmd(SAC_OP_WAKE);
		chk("nap_woken", 0, nap);
		chk("nap_wake_quick", 1, busy_cyc < WAKE_T);
		cmd(SAC_OP_SLEEP);
		chk("sleep", 1, slp);
		chk("sleep_bias", 0, bias);
		chk("host_asleep", 1, asleep);
		cmd(SAC_OP_WAKE);
		chk("sleep_woken", 0, slp);
		chk("bias_back", 1, bias);
		chk("sleep_wake_wait", 1, busy_cyc >= WAKE_T);
		start(777);
		rd();
		test_done();
	end
endmodule
`default_nettype wire
